// ==== src/uasc_pkg.sv ====
package uasc_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [2:0] ADDR_STATUS = 3'h0;
    localparam logic [2:0] ADDR_AUX_STAT = 3'h1;
    localparam logic [2:0] ADDR_AUX_CTL3 = 3'h2;
    localparam logic [2:0] ADDR_DATA = 3'h3;
    localparam logic [2:0] ADDR_FRAME_CTL = 3'h4;

    // receive_aux_status fields
    localparam int S2_LBK = 7;
    localparam int S2_EDGE = 6;
    localparam int S2_RECEIVE_INVERT = 4;
    localparam int S2_WUID = 3;
    localparam int S2_LONG_BREAK_SELECT = 2;
    localparam int S2_LIN_BREAK_DETECT_ENABLE = 1;
    localparam int S2_RAF = 0;

    // aux_control_three fields
    localparam int C3_R8 = 7;
    localparam int C3_T8 = 6;
    localparam int C3_SINGLE_WIRE_PIN_DIRECTION = 5;
    localparam int C3_TRANSMIT_INVERT = 4;

    // primary status fields
    localparam int S1_RECEIVE_FULL_FLAG = 5;
    localparam int S1_IDLE = 4;
    localparam int S1_OR = 3;
    localparam int S1_NF = 2;
    localparam int S1_FE = 1;
    localparam int S1_PF = 0;

    // frame control fields
    localparam int FC_M = 0;
    localparam int FC_RWU = 1;
    localparam int FC_LOOPBACK_SELECT = 2;
    localparam int FC_RECEIVER_SOURCE_SELECT = 3;
    localparam int FC_SBK = 4;

    localparam logic [7:0] RESET_BYTE = 8'h00;

    // Bit-time counts
    localparam int BRK_TX_SHORT = 10;
    localparam int BRK_TX_LONG = 13;
    localparam int BRK_RX_SHORT = 10;
    localparam int BRK_RX_LIN = 11;
    localparam int NINTH_EXTRA = 1;
    localparam int CHAR_BITS_8 = 10;

    typedef enum logic [1:0] {
        UASC_RX_IDLE,
        UASC_RX_FRAME,
        UASC_RX_LOW
    } uasc_rx_e;

    typedef struct packed {
        logic [7:0] addr_unused;
        logic rd;
        logic wr;
        logic [2:0] addr;
        logic [7:0] wdata;
    } uasc_bus_s;

    typedef struct packed {
        logic sbk_q;
        logic [7:0] s2_q;
        logic [7:0] c3_q;
        logic [7:0] s1_q;
        logic [4:0] fc_q;
        logic [7:0] rxbuf_q;
        logic [7:0] txbuf_q;
        logic tx_full_q;
        logic s1_armed_q;
        logic [7:0] rdata_q;
        logic [1:0] rx_sync_q;
        logic rx_prev_q;
        uasc_rx_e rx_st_q;
        logic [15:0] bit_cnt_q;
        logic [4:0] bits_q;
        logic [4:0] low_bits_q;
        logic [4:0] high_bits_q;
        logic [8:0] rx_shift_q;
        logic [3:0] tx_bits_q;
        logic [15:0] tx_cnt_q;
        logic [10:0] tx_shift_q;
        logic tx_busy_q;
        logic tx_line_q;
    } uasc_state_s;

endpackage : uasc_pkg

// ==== src/uasc_core.sv ====
// The register offsets and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module uasc_core
    import uasc_pkg::*;
#(
    parameter int BIT_CYCLES = 16
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic rxd_pin,
    input wire logic txd_pin_in,
    output logic txd_pin_out,
    output logic txd_pin_oe,
    output logic err_irq
);

    initial begin
        if (BIT_CYCLES < 2 || BIT_CYCLES > 65535) begin
            $error("BIT_CYCLES out of range");
        end
    end

    localparam logic [15:0] BIT_LAST = 16'(BIT_CYCLES - 1);
    localparam logic [15:0] BIT_HALF = 16'(BIT_CYCLES / 2);

    uasc_state_s s_q;
    uasc_state_s s_d;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [4:0] with_ninth(input int base, input logic m);
        with_ninth = 5'(base + (m ? NINTH_EXTRA : 0));
    endfunction : with_ninth

    logic mode9;
    logic single_wire;
    logic rx_line;
    logic rx_src;
    assign mode9 = s_q.fc_q[FC_M];
    assign single_wire = s_q.fc_q[FC_LOOPBACK_SELECT] & s_q.fc_q[FC_RECEIVER_SOURCE_SELECT];
    // Loopback takes the internal line; single-wire listens on the tx pin
    assign rx_src = single_wire ? txd_pin_in : (s_q.fc_q[FC_LOOPBACK_SELECT] ? txd_pin_out : rxd_pin);
    assign rx_line = s_q.rx_sync_q[1] ^ s_q.s2_q[S2_RECEIVE_INVERT];

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic bit_tick;
        logic tx_tick;
        logic data_rd;
        logic [4:0] brk_rx_len;
        logic [4:0] frame_len;
        s_d = s_q;
        bit_tick = 1'b0;
        tx_tick = 1'b0;
        data_rd = 1'b0;
        brk_rx_len = s_q.s2_q[S2_LIN_BREAK_DETECT_ENABLE] ? with_ninth(BRK_RX_LIN, mode9)
                                        : with_ninth(BRK_RX_SHORT, mode9);
        frame_len = with_ninth(CHAR_BITS_8, mode9);

        // Two-flop sync; only the second stage feeds logic
        s_d.rx_sync_q = {s_q.rx_sync_q[0], rx_src};
        s_d.rx_prev_q = rx_line;

        // Register writes
        if (reg_wr) begin
            unique case (reg_addr)
                ADDR_AUX_STAT: begin
                    s_d.s2_q[S2_RECEIVE_INVERT] = reg_wdata[S2_RECEIVE_INVERT];
                    s_d.s2_q[S2_WUID] = reg_wdata[S2_WUID];
                    s_d.s2_q[S2_LONG_BREAK_SELECT] = reg_wdata[S2_LONG_BREAK_SELECT];
                    s_d.s2_q[S2_LIN_BREAK_DETECT_ENABLE] = reg_wdata[S2_LIN_BREAK_DETECT_ENABLE];
                    if (reg_wdata[S2_LBK]) s_d.s2_q[S2_LBK] = 1'b0;
                    if (reg_wdata[S2_EDGE]) s_d.s2_q[S2_EDGE] = 1'b0;
                end
                ADDR_AUX_CTL3: begin
                    s_d.c3_q[6:0] = reg_wdata[6:0];
                end
                ADDR_DATA: begin
                    s_d.txbuf_q = reg_wdata;
                    s_d.tx_full_q = 1'b1;
                end
                ADDR_FRAME_CTL: begin
                    s_d.fc_q = reg_wdata[4:0];
                end
                default: begin
                end
            endcase
        end

        // Register reads, data one cycle later
        if (reg_rd) begin
            unique case (reg_addr)
                ADDR_STATUS: s_d.rdata_q = s_q.s1_q;
                ADDR_AUX_STAT: s_d.rdata_q = s_q.s2_q;
                ADDR_AUX_CTL3: s_d.rdata_q = s_q.c3_q;
                ADDR_DATA: s_d.rdata_q = s_q.rxbuf_q;
                ADDR_FRAME_CTL: s_d.rdata_q = {3'h0, s_q.fc_q};
                default: s_d.rdata_q = RESET_BYTE;
            endcase
            if (reg_addr == ADDR_STATUS) begin
                s_d.s1_armed_q = 1'b1;
            end
            if (reg_addr == ADDR_DATA && s_q.s1_armed_q) begin
                data_rd = 1'b1;
                s_d.s1_armed_q = 1'b0;
            end
        end
        if (data_rd) begin
            s_d.s1_q = RESET_BYTE;
        end

        // Receive edge flag
        if (s_q.rx_prev_q && !rx_line) s_d.s2_q[S2_EDGE] = 1'b1;

        // Receiver
        if (s_q.bit_cnt_q == BIT_LAST) begin
            s_d.bit_cnt_q = 16'h0000;
            bit_tick = 1'b1;
        end else begin
            s_d.bit_cnt_q = s_q.bit_cnt_q + 16'h0001;
        end
        unique case (s_q.rx_st_q)
            UASC_RX_IDLE: begin
                if (!rx_line) begin
                    s_d.rx_st_q = UASC_RX_FRAME;
                    s_d.bit_cnt_q = BIT_HALF;
                    s_d.bits_q = 5'h00;
                    s_d.low_bits_q = 5'h00;
                    s_d.high_bits_q = 5'h00;
                    s_d.s2_q[S2_RAF] = 1'b1;
                end
            end
            UASC_RX_FRAME: begin
                if (bit_tick) begin
                    s_d.bits_q = s_q.bits_q + 5'h01;
                    s_d.low_bits_q = rx_line ? 5'h00 : s_q.low_bits_q + 5'h01;
                    if (s_q.bits_q != 5'h00 && s_q.bits_q < frame_len - 5'h01) begin
                        s_d.rx_shift_q = {rx_line, s_q.rx_shift_q[8:1]};
                    end
                    if (s_q.bits_q == frame_len - 5'h01) begin
                        if (!rx_line) begin
                            // Low stop bit: may be a break; keep counting
                            s_d.rx_st_q = UASC_RX_LOW;
                        end else begin
                            s_d.rx_st_q = UASC_RX_IDLE;
                        end
                        // Framing check ignores long break select
                        if (s_q.s2_q[S2_LIN_BREAK_DETECT_ENABLE]) begin
                        end else if (s_q.s1_q[S1_RECEIVE_FULL_FLAG]) begin
                            s_d.s1_q[S1_OR] = 1'b1;
                        end else begin
                            // Nine shifts leave the byte low; eight leave it high
                            s_d.rxbuf_q = mode9 ? s_q.rx_shift_q[7:0] : s_q.rx_shift_q[8:1];
                            s_d.c3_q[C3_R8] = mode9 & s_q.rx_shift_q[8];
                            s_d.s1_q[S1_RECEIVE_FULL_FLAG] = 1'b1;
                            s_d.s1_q[S1_FE] = ~rx_line;
                        end
                    end
                end
            end
            UASC_RX_LOW: begin
                if (bit_tick) begin
                    if (rx_line) begin
                        s_d.rx_st_q = UASC_RX_IDLE;
                    end else if (s_q.low_bits_q == brk_rx_len - 5'h01) begin
                        if (s_q.s2_q[S2_LIN_BREAK_DETECT_ENABLE]) s_d.s2_q[S2_LBK] = 1'b1;
                        s_d.low_bits_q = s_q.low_bits_q + 5'h01;
                    end else if (s_q.low_bits_q < brk_rx_len) begin
                        s_d.low_bits_q = s_q.low_bits_q + 5'h01;
                    end
                end
            end
            default: s_d.rx_st_q = UASC_RX_IDLE;
        endcase

        // Idle line detection clears active and may wake standby
        if (s_q.rx_st_q == UASC_RX_IDLE && bit_tick) begin
            if (s_q.high_bits_q == frame_len - 5'h01) begin
                s_d.s2_q[S2_RAF] = 1'b0;
                if (s_q.fc_q[FC_RWU]) begin
                    s_d.fc_q[FC_RWU] = 1'b0;
                    if (s_q.s2_q[S2_WUID]) s_d.s1_q[S1_IDLE] = 1'b1;
                end
            end
            if (s_q.high_bits_q < frame_len) begin
                s_d.high_bits_q = s_q.high_bits_q + 5'h01;
            end
        end

        // Transmitter
        if (s_q.tx_cnt_q == BIT_LAST) begin
            s_d.tx_cnt_q = 16'h0000;
            tx_tick = 1'b1;
        end else begin
            s_d.tx_cnt_q = s_q.tx_cnt_q + 16'h0001;
        end
        if (!s_q.tx_busy_q) begin
            s_d.tx_line_q = 1'b1;
            if (s_q.fc_q[FC_SBK]) begin
                s_d.tx_busy_q = 1'b1;
                s_d.tx_shift_q = 11'h000;
                s_d.tx_bits_q = 4'(s_q.s2_q[S2_LONG_BREAK_SELECT] ? with_ninth(BRK_TX_LONG, mode9)
                                                      : with_ninth(BRK_TX_SHORT, mode9));
                s_d.tx_cnt_q = 16'h0000;
            end else if (s_q.tx_full_q) begin
                s_d.tx_busy_q = 1'b1;
                s_d.tx_full_q = 1'b0;
                s_d.tx_shift_q = mode9 ? {1'b1, s_q.c3_q[C3_T8], s_q.txbuf_q, 1'b0}
                                       : {2'b11, s_q.txbuf_q, 1'b0};
                s_d.tx_bits_q = 4'(frame_len);
                s_d.tx_cnt_q = 16'h0000;
            end
        end else if (tx_tick) begin
            if (s_q.tx_bits_q == 4'h0) begin
                // Last bit has had its full time; back to mark
                s_d.tx_busy_q = 1'b0;
                s_d.tx_line_q = 1'b1;
            end else begin
                s_d.tx_line_q = s_q.tx_shift_q[0];
                // Top bit refills: ones after a frame, zeros through a long break
                s_d.tx_shift_q = {s_q.tx_shift_q[10], s_q.tx_shift_q[10:1]};
                s_d.tx_bits_q = s_q.tx_bits_q - 4'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            s_q <= '0;
            // Idle line levels, so no false start or edge follows reset
            s_q.rx_sync_q <= 2'b11;
            s_q.rx_prev_q <= 1'b1;
            s_q.tx_line_q <= 1'b1;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign reg_rdata = s_q.rdata_q;
    assign txd_pin_out = s_q.tx_line_q ^ s_q.c3_q[C3_TRANSMIT_INVERT];
    assign txd_pin_oe = single_wire ? s_q.c3_q[C3_SINGLE_WIRE_PIN_DIRECTION] : 1'b1;
    assign err_irq = (s_q.c3_q[3] & s_q.s1_q[S1_OR])
                   | (s_q.c3_q[2] & s_q.s1_q[S1_NF])
                   | (s_q.c3_q[1] & s_q.s1_q[S1_FE])
                   | (s_q.c3_q[0] & s_q.s1_q[S1_PF]);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_IRQ_OR: assert property (@(posedge ref_clk) disable iff (!resetn)
        (s_q.c3_q[3] && s_q.s1_q[S1_OR]) |-> err_irq) else $error("overrun irq missing");
    AST_IRQ_NF: assert property (@(posedge ref_clk) disable iff (!resetn)
        (s_q.c3_q[2] && s_q.s1_q[S1_NF]) |-> err_irq) else $error("noise irq missing");
    AST_IRQ_FE: assert property (@(posedge ref_clk) disable iff (!resetn)
        (s_q.c3_q[1] && s_q.s1_q[S1_FE]) |-> err_irq) else $error("framing irq missing");
    AST_IRQ_PF: assert property (@(posedge ref_clk) disable iff (!resetn)
        (s_q.c3_q[0] && s_q.s1_q[S1_PF]) |-> err_irq) else $error("parity irq missing");
    AST_IRQ_NONE: assert property (@(posedge ref_clk) disable iff (!resetn)
        ((s_q.c3_q[3:0] & {s_q.s1_q[S1_OR], s_q.s1_q[S1_NF], s_q.s1_q[S1_FE],
        s_q.s1_q[S1_PF]}) == 4'h0) |-> !err_irq) else $error("spurious irq");
    AST_LIN_NO_RECEIVE_FULL_FLAG: assert property (@(posedge ref_clk) disable iff (!resetn)
        (clk_en && s_q.s2_q[S2_LIN_BREAK_DETECT_ENABLE] && !s_q.s1_q[S1_RECEIVE_FULL_FLAG]) |=> !s_q.s1_q[S1_RECEIVE_FULL_FLAG])
        else $error("receive-full set under LIN detect");
    AST_DIR: assert property (@(posedge ref_clk) disable iff (!resetn)
        single_wire |-> (txd_pin_oe == s_q.c3_q[C3_SINGLE_WIRE_PIN_DIRECTION])) else $error("pin direction");
    AST_TRANSMIT_INVERT: assert property (@(posedge ref_clk) disable iff (!resetn)
        !s_q.tx_busy_q && !$past(s_q.tx_busy_q) |-> txd_pin_out == ~s_q.c3_q[C3_TRANSMIT_INVERT])
        else $error("idle level not inverted");
    AST_EDGE: assert property (@(posedge ref_clk) disable iff (!resetn)
        (clk_en && s_q.rx_prev_q && !rx_line) |=> s_q.s2_q[S2_EDGE])
        else $error("edge flag missed");

endmodule : uasc_core

`default_nettype wire

// ==== tb/uasc_node.sv ====
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Remote serial node
// ------------------------------------------------------------
module uasc_node #(
    parameter int BC = 4
) (
    input wire logic clk,
    input wire logic line_in,
    output logic line_out
);
    // Mark level between frames, as a real node idles
    initial line_out = 1'b1;

    // LSB first, one bit every BC clocks
    task automatic send_bits(input logic [15:0] bits, input int n);
        for (int i = 0; i < n; i++) begin
            line_out <= bits[i];
            repeat (BC) @(posedge clk);
        end
        line_out <= 1'b1;
    endtask : send_bits

    // Mid-bit sampling, tolerant of the sync delay in the device
    task automatic get_frame(output logic [8:0] d, input int nd);
        d = '0;
        @(negedge line_in);
        repeat (BC + BC / 2) @(posedge clk);
        for (int i = 0; i < nd; i++) begin
            d[i] = line_in;
            repeat (BC) @(posedge clk);
        end
    endtask : get_frame

    // Clocks spent low, sampled after each edge has settled
    task automatic low_len(output int n);
        n = 0;
        @(negedge line_in);
        while (line_in === 1'b0) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask : low_len
endmodule : uasc_node

`default_nettype wire

// ==== tb/test_uart_aux_status_control.sv ====
`timescale 1ns/1ps
`default_nettype none

module test_uart_aux_status_control;
    import uasc_pkg::*;
    localparam int BC = 4;
    logic ref_clk, resetn, clk_en, reg_wr, reg_rd, rxd_pin, txd_pin_in;
    logic txd_pin_out, txd_pin_oe, err_irq;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, d;
    logic [8:0] f;
    int n, errors, samples_checked, cycles;

    // ------------------------------------------------------------
    // Design and remote node
    // ------------------------------------------------------------
    uasc_core #(.BIT_CYCLES(BC)) uasc_core_inst (.ref_clk(ref_clk), .resetn(resetn),
        .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rxd_pin(rxd_pin),
        .txd_pin_in(txd_pin_in), .txd_pin_out(txd_pin_out), .txd_pin_oe(txd_pin_oe),
        .err_irq(err_irq));
    uasc_node #(.BC(BC)) uasc_node_inst (.clk(ref_clk), .line_in(txd_pin_out),
        .line_out(rxd_pin));
    // Pulled-up single wire when nobody drives it
    assign txd_pin_in = txd_pin_oe ? txd_pin_out : 1'b1;

    always #50 ref_clk = ~ref_clk;

    // ------------------------------------------------------------
    // Bus, compare and closing tasks
    // ------------------------------------------------------------
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask : rd

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic final_report();
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : final_report

    task automatic bits_wait(input int k);
        repeat (k * BC) @(posedge ref_clk);
    endtask : bits_wait

    // Status read then data read empties the primary flags
    task automatic drain();
        rd(ADDR_STATUS, d);
        rd(ADDR_DATA, d);
    endtask : drain

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rd(ADDR_AUX_STAT, d);
        chk("aux status reset", {8'h00, RESET_BYTE}, {8'h00, d});
        rd(ADDR_AUX_CTL3, d);
        chk("aux control reset", {8'h00, RESET_BYTE}, {8'h00, d});
        rd(3'h5, d);
        chk("unmapped read", 16'h0000, {8'h00, d});
        chk("idle tx level", 16'h0001, {15'h0000, txd_pin_out});
    endtask : t_reset

    task automatic t_edge();
        uasc_node_inst.send_bits(16'h0000, 1);
        bits_wait(12);
        rd(ADDR_AUX_STAT, d);
        chk("falling edge flag", 16'h0001, {15'h0000, d[S2_EDGE]});
        wr(ADDR_AUX_STAT, 8'h40);
        rd(ADDR_AUX_STAT, d);
        chk("edge flag cleared", 16'h0000, {15'h0000, d[S2_EDGE]});
        drain();
        wr(ADDR_AUX_STAT, 8'h10);
        // Inverting an idle line is itself an active edge
        wr(ADDR_AUX_STAT, 8'h50);
        fork
            uasc_node_inst.send_bits(16'h0000, 12);
            begin
                bits_wait(4);
                rd(ADDR_AUX_STAT, d);
                chk("inverted falling ignored", 16'h0000, {15'h0000, d[S2_EDGE]});
            end
        join
        bits_wait(2);
        rd(ADDR_AUX_STAT, d);
        chk("inverted rising flag", 16'h0001, {15'h0000, d[S2_EDGE]});
        wr(ADDR_AUX_STAT, 8'h40);
        bits_wait(12);
        drain();
    endtask : t_edge

    task automatic t_tx();
        fork
            uasc_node_inst.get_frame(f, 8);
            wr(ADDR_DATA, 8'hA5);
        join
        chk("tx byte", 16'h00A5, {7'h00, f});
        wr(ADDR_FRAME_CTL, 8'h01);
        wr(ADDR_AUX_CTL3, 8'h40);
        fork
            uasc_node_inst.get_frame(f, 9);
            wr(ADDR_DATA, 8'h3C);
        join
        chk("tx nine bits", 16'h013C, {7'h00, f});
        fork
            uasc_node_inst.get_frame(f, 9);
            wr(ADDR_DATA, 8'hC3);
        join
        chk("tx ninth held", 16'h01C3, {7'h00, f});
        bits_wait(3);
        wr(ADDR_AUX_CTL3, 8'h10);
        chk("inverted idle", 16'h0000, {15'h0000, txd_pin_out});
        wr(ADDR_AUX_CTL3, 8'h00);
        wr(ADDR_FRAME_CTL, 8'h00);
    endtask : t_tx

    // Break length per long select and 9-bit mode
    task automatic t_brk();
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_AUX_STAT, {5'h00, i[1], 2'h0});
            wr(ADDR_FRAME_CTL, {7'h00, i[0]});
            fork
                uasc_node_inst.low_len(n);
                begin
                    wr(ADDR_FRAME_CTL, {7'h08, i[0]});
                    wr(ADDR_FRAME_CTL, {7'h00, i[0]});
                end
            join
            chk("break length", 16'(((i[1] ? BRK_TX_LONG : BRK_TX_SHORT) + i[0]) * BC), 16'(n));
            bits_wait(2);
        end
        wr(ADDR_AUX_STAT, 8'h00);
        wr(ADDR_FRAME_CTL, 8'h00);
    endtask : t_brk

    task automatic t_rx9();
        wr(ADDR_FRAME_CTL, 8'h01);
        fork
            uasc_node_inst.send_bits({5'h1F, 1'b1, 1'b1, 8'h96, 1'b0}, 11);
            begin
                bits_wait(3);
                rd(ADDR_AUX_STAT, d);
                chk("receiver active", 16'h0001, {15'h0000, d[S2_RAF]});
            end
        join
        bits_wait(12);
        rd(ADDR_AUX_STAT, d);
        chk("receiver idle again", 16'h0000, {15'h0000, d[S2_RAF]});
        rd(ADDR_STATUS, d);
        chk("receive full", 16'h0001, {15'h0000, d[S1_RECEIVE_FULL_FLAG]});
        rd(ADDR_AUX_CTL3, d);
        chk("rx ninth bit", 16'h0001, {15'h0000, d[C3_R8]});
        rd(ADDR_DATA, d);
        chk("rx byte", 16'h0096, {8'h00, d});
        rd(ADDR_STATUS, d);
        chk("receive full cleared", 16'h0000, {15'h0000, d[S1_RECEIVE_FULL_FLAG]});
        wr(ADDR_FRAME_CTL, 8'h00);
    endtask : t_rx9

    task automatic t_err();
        wr(ADDR_AUX_CTL3, 8'h02);
        wr(ADDR_AUX_STAT, 8'h04);
        uasc_node_inst.send_bits({6'h00, 8'h55, 1'b0}, 10);
        bits_wait(4);
        rd(ADDR_STATUS, d);
        chk("framing flag", 16'h0001, {15'h0000, d[S1_FE]});
        chk("framing irq", 16'h0001, {15'h0000, err_irq});
        wr(ADDR_AUX_CTL3, 8'h00);
        chk("framing irq masked", 16'h0000, {15'h0000, err_irq});
        wr(ADDR_AUX_CTL3, 8'h02);
        drain();
        chk("irq after clear", 16'h0000, {15'h0000, err_irq});
        wr(ADDR_AUX_CTL3, 8'h08);
        wr(ADDR_AUX_STAT, 8'h00);
        uasc_node_inst.send_bits({6'h3F, 8'h11, 1'b0}, 10);
        @(posedge ref_clk);
        uasc_node_inst.send_bits({6'h3F, 8'h22, 1'b0}, 10);
        bits_wait(4);
        chk("overrun irq", 16'h0001, {15'h0000, err_irq});
        rd(ADDR_STATUS, d);
        chk("overrun flag", 16'h0001, {15'h0000, d[S1_OR]});
        rd(ADDR_DATA, d);
        chk("first byte kept", 16'h0011, {8'h00, d});
        wr(ADDR_AUX_CTL3, 8'h05);
        chk("noise parity idle", 16'h0000, {15'h0000, err_irq});
        wr(ADDR_AUX_CTL3, 8'h00);
    endtask : t_err

    task automatic t_lin();
        wr(ADDR_AUX_STAT, 8'h02);
        uasc_node_inst.send_bits(16'h0000, 10);
        bits_wait(12);
        rd(ADDR_AUX_STAT, d);
        chk("ten low no lin", 16'h0000, {15'h0000, d[S2_LBK]});
        rd(ADDR_STATUS, d);
        chk("full and framing held", 16'h0000, {14'h0000, d[S1_RECEIVE_FULL_FLAG], d[S1_FE]});
        uasc_node_inst.send_bits(16'h0000, 12);
        bits_wait(12);
        rd(ADDR_AUX_STAT, d);
        chk("lin break flag", 16'h0001, {15'h0000, d[S2_LBK]});
        wr(ADDR_AUX_STAT, 8'h82);
        rd(ADDR_AUX_STAT, d);
        chk("lin flag cleared", 16'h0000, {15'h0000, d[S2_LBK]});
        wr(ADDR_AUX_STAT, 8'h00);
        drain();
        for (int k = 1; k >= 0; k--) begin
            wr(ADDR_AUX_STAT, {4'h0, k[0], 3'h0});
            wr(ADDR_FRAME_CTL, 8'h02);
            uasc_node_inst.send_bits({6'h3F, 8'hAA, 1'b0}, 10);
            bits_wait(12);
            rd(ADDR_STATUS, d);
            chk("wake idle flag", {15'h0000, k[0]}, {15'h0000, d[S1_IDLE]});
            drain();
        end
        wr(ADDR_AUX_STAT, 8'h00);
        wr(ADDR_FRAME_CTL, 8'h00);
    endtask : t_lin

    task automatic t_dir();
        wr(ADDR_FRAME_CTL, 8'h0C);
        wr(ADDR_AUX_CTL3, 8'h00);
        chk("single wire input", 16'h0000, {15'h0000, txd_pin_oe});
        wr(ADDR_AUX_CTL3, 8'h20);
        chk("single wire output", 16'h0001, {15'h0000, txd_pin_oe});
        wr(ADDR_FRAME_CTL, 8'h00);
        // Clock enable low must swallow a write
        @(posedge ref_clk);
        clk_en <= 1'b0;
        wr(ADDR_AUX_CTL3, 8'h10);
        @(posedge ref_clk);
        clk_en <= 1'b1;
        #1;
        chk("frozen write ignored", 16'h0001, {15'h0000, txd_pin_out});
    endtask : t_dir

    // ------------------------------------------------------------
    // Main sequence and hang guard
    // ------------------------------------------------------------
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            final_report();
        end
    end

    initial begin
        ref_clk = 1'b0;
        resetn = 1'b0;
        clk_en = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 3'h0;
        reg_wdata = 8'h00;
        repeat (3) @(posedge ref_clk);
        resetn <= 1'b1;
        t_reset();
        t_edge();
        t_tx();
        t_brk();
        t_rx9();
        t_err();
        t_lin();
        t_dir();
        final_report();
    end
endmodule : test_uart_aux_status_control

`default_nettype wire
